/* capcmp_consts.vh */
// Purpose: shared constants for the capture/compare unit
// Assumes: byte-wide registers, each in one aligned 32-bit word
// Notes: printed offsets are register indices; byte address is index*4
`ifndef CAPCMP_CONSTS_VH
`define CAPCMP_CONSTS_VH

`define IDX_PIN_OUTPUT_DATA 8'h07
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_PERIPH_IRQ_FLAGS 8'h0c
`define IDX_TIMER_COUNT_LOW 8'h0e
`define IDX_TIMER_COUNT_HIGH 8'h0f
`define IDX_TIMER_CONTROL 8'h10
`define IDX_CAPCMP_VALUE_LOW 8'h15
`define IDX_CAPCMP_VALUE_HIGH 8'h16
`define IDX_CAPCMP_CONTROL 8'h17
`define IDX_PIN_DIRECTION 8'h87
`define IDX_PERIPH_IRQ_ENABLES 8'h8c

`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SWINT 4'ha
`define MODE_CMP_TRIG 4'hb

`define BIT_UNIT_PIN 2
`define BIT_CAPCMP_FLAG 2
`define BIT_TIMER_OVF_FLAG 0
`define BIT_TIMER_ON 0

`define RST_PIN_DIRECTION 8'h05
`define RST_ZERO8 8'h00
`define PRESC_DIV4 4'h3
`define PRESC_DIV16 4'hf

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

/* edge_sync.v */
// Purpose: bring the unit pin into the clock domain and find edges
// Assumes: pin may change at any time
// Notes: first stage is only read by the second stage
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input wire aclk,
	input wire aresetn,
	input wire pin_in,
	output reg rise_pulse,
	output reg fall_pulse
);
	reg meta_r;
	reg sync_r;
	reg last_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
			rise_pulse <= 1'b0;
			fall_pulse <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
			rise_pulse <= sync_r & ~last_r;
			fall_pulse <= ~sync_r & last_r;
		end
	end
endmodule
`default_nettype wire

/* capture_prescaler.v */
// Purpose: count qualified edges and flag each capture event
// Assumes: mode code from the control register, edges one cycle wide
// Notes: counter held at zero outside capture modes
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_consts.vh"
module capture_prescaler #(
	parameter CNT_W = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] mode,
	input wire rise_pulse,
	input wire fall_pulse,
	output reg capture_event
);
	reg [CNT_W-1:0] count_r;
	reg [CNT_W-1:0] limit;
	reg is_cap;
	always @* begin
		is_cap = (mode[3:2] == 2'b01);
		limit = {CNT_W{1'b0}};
		if (mode == `MODE_CAP_RISE4)
			limit = `PRESC_DIV4;
		else if (mode == `MODE_CAP_RISE16)
			limit = `PRESC_DIV16;
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= {CNT_W{1'b0}};
			capture_event <= 1'b0;
		end else begin
			capture_event <= 1'b0;
			if (!is_cap) begin
				count_r <= {CNT_W{1'b0}};
			end else if (mode == `MODE_CAP_FALL) begin
				capture_event <= fall_pulse;
			end else if (rise_pulse) begin
				if (count_r >= limit) begin
					count_r <= {CNT_W{1'b0}};
					capture_event <= 1'b1;
				end else begin
					count_r <= count_r + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* capture_compare_unit.v */
// Purpose: capture/compare unit with its timer and register file
// Assumes: AXI4-Lite slave, byte registers in low data bits
// Notes: no PWM; converter start is a one-cycle pulse output
// Summary of operation
// - Output data write reaches capture input when pin is output
// - Mode change may raise a false flag
// - Prescaler cleared when off or not capturing
// - Prescale switch keeps count, may flag
// - Match drives pin high, low, unchanged
// - Match flag set with pin action
// - Zero control forces compare latch low
// - Software interrupt mode only sets flag
// - Trigger mode match clears the timer
// - Trigger mode pulses converter start
// - Trigger clear never sets overflow flag
// - Capture sets flag; copies timer unless control written
// - Falling, rising, 4th, 16th rising edges
// - New capture overwrites unread value
// - Code 1011 triggers; timer write wins
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_consts.vh"
module capture_compare_unit (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire unit_pin_in,
	output reg unit_pin_out,
	output reg unit_pin_oe_n,
	output reg adc_start,
	input wire adc_enable
);
	reg [7:0] pin_output_data_r;
	reg [7:0] interrupt_control_r;
	reg [7:0] flags_r;
	reg [7:0] enables_r;
	reg [15:0] timer_r;
	reg [7:0] timer_control_r;
	reg [15:0] value_r;
	reg [7:0] control_r;
	reg [7:0] pin_direction_r;
	reg cmp_latch_r;
	reg [11:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg have_aw_r;
	reg have_w_r;
	wire rise_pulse;
	wire fall_pulse;
	wire capture_event;
	wire [3:0] mode = control_r[3:0];
	reg match_seen_r;
	wire is_compare = mode[3] && (mode[2] == 1'b0);
	wire match = is_compare && (timer_r == value_r) && !match_seen_r;

	function [7:0] word_index;
		input [11:0] addr;
		word_index = addr[9:2];
	endfunction

	function known_index;
		input [7:0] idx;
		known_index = (idx == `IDX_PIN_OUTPUT_DATA) ||
			(idx == `IDX_INTERRUPT_CONTROL) ||
			(idx == `IDX_PERIPH_IRQ_FLAGS) ||
			(idx == `IDX_TIMER_COUNT_LOW) ||
			(idx == `IDX_TIMER_COUNT_HIGH) ||
			(idx == `IDX_TIMER_CONTROL) ||
			(idx == `IDX_CAPCMP_VALUE_LOW) ||
			(idx == `IDX_CAPCMP_VALUE_HIGH) ||
			(idx == `IDX_CAPCMP_CONTROL) ||
			(idx == `IDX_PIN_DIRECTION) ||
			(idx == `IDX_PERIPH_IRQ_ENABLES);
	endfunction

	// Pin level as seen by capture: own drive when output
	// output data loops to capture input
	wire pin_seen = pin_direction_r[`BIT_UNIT_PIN] ? unit_pin_in :
		unit_pin_out;

	edge_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(pin_seen),
		.rise_pulse(rise_pulse),
		.fall_pulse(fall_pulse)
	);

	capture_prescaler #(.CNT_W(4)) u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.mode(mode),
		.rise_pulse(rise_pulse),
		.fall_pulse(fall_pulse),
		.capture_event(capture_event)
	);

	wire do_write = have_aw_r && have_w_r && !s_axi_bvalid;
	wire [7:0] widx = word_index(awaddr_r);
	wire wlane = wstrb_r[0];
	wire [7:0] wbyte = wdata_r[7:0];
	wire wr_timer = do_write && wlane &&
		((widx == `IDX_TIMER_COUNT_LOW) ||
		(widx == `IDX_TIMER_COUNT_HIGH));
	wire wr_ctrl = do_write && wlane && (widx == `IDX_CAPCMP_CONTROL);
	wire wr_flags = do_write && wlane && (widx == `IDX_PERIPH_IRQ_FLAGS);
	wire trig = match && (mode == `MODE_CMP_TRIG);
	wire overflow = timer_control_r[`BIT_TIMER_ON] &&
		(timer_r == 16'hffff) && !trig && !wr_timer;
	// Mode change into or among capture codes may flag spuriously
	// false flag on capture mode change
	wire spurious = wr_ctrl && (wbyte[3:2] == 2'b01) &&
		(wbyte[3:0] != mode) && (mode != `MODE_OFF);

	// Write channel capture, either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_r <= 1'b0;
			have_w_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_RESP_OKAY;
		end else begin
			s_axi_awready <= !have_aw_r && !s_axi_awready &&
				s_axi_awvalid;
			s_axi_wready <= !have_w_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_index(widx) ? `AXI_RESP_OKAY :
					`AXI_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				have_aw_r <= 1'b0;
				have_w_r <= 1'b0;
			end
		end
	end

	// Read channel; one cycle decode, held until taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `AXI_RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (word_index(s_axi_araddr) == `IDX_PIN_OUTPUT_DATA)
					s_axi_rdata[7:0] <= pin_output_data_r;
				else if (word_index(s_axi_araddr) == `IDX_INTERRUPT_CONTROL)
					s_axi_rdata[7:0] <= interrupt_control_r;
				else if (word_index(s_axi_araddr) == `IDX_PERIPH_IRQ_FLAGS)
					s_axi_rdata[7:0] <= flags_r;
				else if (word_index(s_axi_araddr) == `IDX_TIMER_COUNT_LOW)
					s_axi_rdata[7:0] <= timer_r[7:0];
				else if (word_index(s_axi_araddr) == `IDX_TIMER_COUNT_HIGH)
					s_axi_rdata[7:0] <= timer_r[15:8];
				else if (word_index(s_axi_araddr) == `IDX_TIMER_CONTROL)
					s_axi_rdata[7:0] <= timer_control_r;
				else if (word_index(s_axi_araddr) == `IDX_CAPCMP_VALUE_LOW)
					s_axi_rdata[7:0] <= value_r[7:0];
				else if (word_index(s_axi_araddr) == `IDX_CAPCMP_VALUE_HIGH)
					s_axi_rdata[7:0] <= value_r[15:8];
				else if (word_index(s_axi_araddr) == `IDX_CAPCMP_CONTROL)
					s_axi_rdata[7:0] <= control_r;
				else if (word_index(s_axi_araddr) == `IDX_PIN_DIRECTION)
					s_axi_rdata[7:0] <= pin_direction_r;
				else if (word_index(s_axi_araddr) == `IDX_PERIPH_IRQ_ENABLES)
					s_axi_rdata[7:0] <= enables_r;
				else
					s_axi_rresp <= `AXI_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Register file, timer, capture and compare actions
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_output_data_r <= `RST_ZERO8;
			interrupt_control_r <= `RST_ZERO8;
			flags_r <= `RST_ZERO8;
			enables_r <= `RST_ZERO8;
			timer_r <= 16'h0000;
			timer_control_r <= `RST_ZERO8;
			value_r <= 16'h0000;
			control_r <= `RST_ZERO8;
			pin_direction_r <= `RST_PIN_DIRECTION;
			cmp_latch_r <= 1'b0;
			match_seen_r <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			// One action per match until timer moves off the value
			match_seen_r <= is_compare && (timer_r == value_r);
			if (wr_timer) begin
				if (widx == `IDX_TIMER_COUNT_LOW)
					timer_r[7:0] <= wbyte;
				else
					timer_r[15:8] <= wbyte;
			end else if (trig) begin
				timer_r <= 16'h0000;
			end else if (timer_control_r[`BIT_TIMER_ON]) begin
				timer_r <= timer_r + 16'h0001;
			end
			if (trig && adc_enable)
				adc_start <= 1'b1;
			if (match && mode == `MODE_CMP_SET)
				cmp_latch_r <= 1'b1;
			else if (match && mode == `MODE_CMP_CLEAR)
				cmp_latch_r <= 1'b0;
			if (wr_ctrl && wbyte == `RST_ZERO8)
				cmp_latch_r <= 1'b0;
			if (do_write && wlane) begin
				if (widx == `IDX_PIN_OUTPUT_DATA)
					pin_output_data_r <= wbyte;
				else if (widx == `IDX_INTERRUPT_CONTROL)
					interrupt_control_r <= wbyte;
				else if (widx == `IDX_PERIPH_IRQ_FLAGS)
					flags_r <= wbyte;
				else if (widx == `IDX_TIMER_CONTROL)
					timer_control_r <= wbyte;
				else if (widx == `IDX_CAPCMP_VALUE_LOW)
					value_r[7:0] <= wbyte;
				else if (widx == `IDX_CAPCMP_VALUE_HIGH)
					value_r[15:8] <= wbyte;
				else if (widx == `IDX_CAPCMP_CONTROL)
					// mode codes held in low nibble
					control_r <= {2'b00, wbyte[5:0]};
				else if (widx == `IDX_PIN_DIRECTION)
					pin_direction_r <= wbyte;
				else if (widx == `IDX_PERIPH_IRQ_ENABLES)
					enables_r <= wbyte;
			end
			if (capture_event && !wr_ctrl)
				value_r <= timer_r;
			// Hardware sets win over a same-cycle flag write
			// flag with compare action
			if (match || capture_event || spurious)
				flags_r[`BIT_CAPCMP_FLAG] <= 1'b1;
			if (overflow)
				flags_r[`BIT_TIMER_OVF_FLAG] <= 1'b1;
		end
	end

	// Pin outputs registered; oe_n low drives the pin
	always @(posedge aclk) begin
		if (!aresetn) begin
			unit_pin_out <= 1'b0;
			unit_pin_oe_n <= 1'b1;
		end else begin
			unit_pin_oe_n <= pin_direction_r[`BIT_UNIT_PIN];
			unit_pin_out <= is_compare ? cmp_latch_r :
				pin_output_data_r[`BIT_UNIT_PIN];
		end
	end
endmodule
`default_nettype wire

/* capcmp_checker.sv */
// Purpose: port-level checks of the capture/compare unit
// Assumes: sees only the top module ports
// Notes: bound to the unit after the module
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_consts.vh"
module capcmp_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic unit_pin_oe_n,
	input wire logic adc_start,
	input wire logic adc_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Both halves are registered first, so the answer is two edges on
	chk_wr_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response late");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
		else $error("upper read bits set");
	chk_bresp_code: assert property (s_axi_bvalid |->
		s_axi_bresp == `AXI_RESP_OKAY || s_axi_bresp == `AXI_RESP_SLVERR)
		else $error("bad write response code");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
	chk_adc_pulse: assert property (adc_start |=> !adc_start)
		else $error("converter start too long");
	chk_adc_gate: assert property (adc_start |-> adc_enable)
		else $error("converter start while disabled");
	// Reset itself is the antecedent here
	chk_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> unit_pin_oe_n && !adc_start && !s_axi_bvalid)
		else $error("outputs active after reset");
endmodule
bind capture_compare_unit capcmp_checker chk_u (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .unit_pin_oe_n(unit_pin_oe_n),
	.adc_start(adc_start), .adc_enable(adc_enable));
`default_nettype wire

/* pin_model.sv */
// Purpose: far-side model of the unit signal pin
// Assumes: no pull on the pin; exactly one party drives it
// Notes: bench sets the external level
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	input wire logic unit_pin_out,
	input wire logic unit_pin_oe_n,
	input wire logic ext_level,
	output logic pin_level
);
	assign pin_level = unit_pin_oe_n ? ext_level : unit_pin_out;
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for the capture/compare unit
// Assumes: AXI4-Lite master, byte address is index times four
// Notes: timer is stopped before captures so values are known
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_consts.vh"
module testbench;
	logic aclk = 0, aresetn = 0, ext_level = 0, adc_enable = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rv;
	logic [1:0] rr;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire awready, wready, bvalid, arready, rvalid;
	wire pin_out, oe_n, adc_start, pin_level;
	int miscompares = 0, checked = 0, pulses = 0, gap = 0, period = 0;
	always #10 aclk = ~aclk;
	// Cycles between the last two converter starts
	always @(posedge aclk) begin
		if (adc_start) pulses <= pulses + 1;
		gap <= adc_start ? 1 : gap + 1;
		if (adc_start) period <= gap;
	end
	capture_compare_unit dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.unit_pin_in(pin_level), .unit_pin_out(pin_out),
		.unit_pin_oe_n(oe_n), .adc_start(adc_start), .adc_enable(adc_enable));
	pin_model pin_u (.unit_pin_out(pin_out), .unit_pin_oe_n(oe_n),
		.ext_level(ext_level), .pin_level(pin_level));
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] i, d);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= {2'b0, i, 2'b0};
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid && n < 50);
		rr = bresp;
		bready <= 0;
		chk(n < 50, 1, "write answer");
	endtask
	task automatic rc(input logic [7:0] i, input logic [31:0] e,
		input string nm);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= {2'b0, i, 2'b0};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 0;
		end while (!rvalid && n < 50);
		rv = rdata;
		rr = rresp;
		rready <= 0;
		chk(n < 50, 1, "read answer");
		chk(rv, e, nm);
	endtask
	task automatic tset(input logic [15:0] t);
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_COUNT_LOW, t[7:0]);
		wr(`IDX_TIMER_COUNT_HIGH, t[15:8]);
	endtask
	task automatic edge1(input logic v);
		ext_level <= v;
		repeat (10) @(posedge aclk);
	endtask
	task automatic t_reset;
		rc(`IDX_CAPCMP_CONTROL, 0, "control reset");
		rc(`IDX_PIN_DIRECTION, `RST_PIN_DIRECTION, "direction reset");
		rc(`IDX_TIMER_CONTROL, 0, "timer control reset");
		rc(8'h20, 0, "unmapped data");
		chk(rr, `AXI_RESP_SLVERR, "unmapped response");
		chk(oe_n, 1, "pin released");
		$display("test reset done");
	endtask
	task automatic cmp(input logic [3:0] m, input logic p);
		tset(16'h0000);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		wr(`IDX_CAPCMP_CONTROL, {4'h0, m});
		wr(`IDX_TIMER_CONTROL, 8'h01);
		repeat (40) @(posedge aclk);
		chk(pin_out, p, "pin action");
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "match flag");
	endtask
	task automatic t_cmp;
		wr(`IDX_PIN_DIRECTION, 8'h01);
		wr(`IDX_CAPCMP_VALUE_LOW, 8'h10);
		wr(`IDX_CAPCMP_VALUE_HIGH, 8'h00);
		cmp(`MODE_CMP_SET, 1);
		cmp(`MODE_CMP_CLEAR, 0);
		cmp(`MODE_CMP_SET, 1);
		// Latch must be low again before a pin-neutral mode
		wr(`IDX_CAPCMP_CONTROL, 0);
		cmp(`MODE_CMP_SWINT, 0);
		chk(oe_n, 0, "pin driven");
		$display("test compare done");
	endtask
	task automatic t_trig;
		tset(0);
		wr(`IDX_CAPCMP_VALUE_LOW, 8'h08);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		adc_enable <= 1;
		wr(`IDX_CAPCMP_CONTROL, {4'h0, `MODE_CMP_TRIG});
		pulses = 0;
		wr(`IDX_TIMER_CONTROL, 8'h01);
		repeat (300) @(posedge aclk);
		chk(pulses > 20, 1, "converter starts");
		rc(`IDX_TIMER_COUNT_HIGH, 0, "timer kept short");
		chk(period, 9, "timer period");
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "no overflow flag");
		// Trigger at the top count must still not flag an overflow
		tset(16'hfff0);
		wr(`IDX_CAPCMP_VALUE_LOW, 8'hff);
		wr(`IDX_CAPCMP_VALUE_HIGH, 8'hff);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		adc_enable <= 0;
		pulses = 0;
		wr(`IDX_TIMER_CONTROL, 8'h01);
		repeat (100) @(posedge aclk);
		chk(pulses, 0, "converter disabled");
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "trigger at top");
		wr(`IDX_CAPCMP_CONTROL, 0);
		$display("test trigger done");
	endtask
	task automatic cap(input logic [3:0] m, input int n, input logic [15:0] t);
		wr(`IDX_CAPCMP_CONTROL, 0);
		tset(t);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		wr(`IDX_CAPCMP_CONTROL, {4'h0, m});
		repeat (n - 1) begin
			edge1(1);
			edge1(0);
		end
		rc(`IDX_PERIPH_IRQ_FLAGS, 0, "no early capture");
		edge1(1);
		rc(`IDX_PERIPH_IRQ_FLAGS, {5'h0, m != `MODE_CAP_FALL, 2'h0},
			"edge kind");
		edge1(0);
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "capture flag");
		rc(`IDX_CAPCMP_VALUE_LOW, t[7:0], "value low");
		rc(`IDX_CAPCMP_VALUE_HIGH, t[15:8], "value high");
	endtask
	task automatic t_cap;
		wr(`IDX_PIN_DIRECTION, `RST_PIN_DIRECTION);
		cap(`MODE_CAP_RISE, 1, 16'h1234);
		cap(`MODE_CAP_FALL, 1, 16'h5678);
		cap(`MODE_CAP_RISE4, 4, 16'h9abc);
		// Leave a partial count that turning off must discard
		edge1(1);
		edge1(0);
		edge1(1);
		edge1(0);
		cap(`MODE_CAP_RISE4, 4, 16'hdef0);
		cap(`MODE_CAP_RISE16, 16, 16'h0ff1);
		// Direct prescale switch keeps a count of two and flags
		edge1(1);
		edge1(0);
		edge1(1);
		edge1(0);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		wr(`IDX_CAPCMP_CONTROL, {4'h0, `MODE_CAP_RISE4});
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "switch flag");
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		edge1(1);
		edge1(0);
		rc(`IDX_PERIPH_IRQ_FLAGS, 0, "kept count short");
		edge1(1);
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "kept count");
		edge1(0);
		wr(`IDX_CAPCMP_CONTROL, 0);
		wr(`IDX_PERIPH_IRQ_FLAGS, 0);
		wr(`IDX_PIN_DIRECTION, 8'h01);
		wr(`IDX_CAPCMP_CONTROL, {4'h0, `MODE_CAP_RISE});
		wr(`IDX_PIN_OUTPUT_DATA, 8'h04);
		repeat (10) @(posedge aclk);
		rc(`IDX_PERIPH_IRQ_FLAGS, 8'h04, "data write capture");
		$display("test capture done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_cmp;
		t_trig;
		t_cap;
		conclude;
	end
	// Run needs under two thousand cycles; allow generous margin
	initial begin
		#400000;
		miscompares++;
		conclude;
	end
endmodule
`default_nettype wire
